// ### design/calibration_menu_sequencer.sv
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "cal_menu_defines.svh"

// Overview of operation
// R1: function key held three seconds in measurement enters function selection.
// R2: right key steps digital span, load calibration, full calibration in order.
// R3: digital span runs division, capacity, zero, rated output, then completion.
// R4: cancel drops the entry and returns to the current mode's top display.
// R5: right selects digit, up/down change it, enter stores and advances.
// R6: enter at zero step captures present reading as zero point.
// R7: load mode: zero, span weight entry, span shown two seconds, completion.
// R8: enter at completion returns to top; top right next mode, cancel measures.
// R9: full mode: division, capacity, zero, span, show span, completion, top.
// R10: capacity accepted only if resolution below 10000.
// R11: operator uses heavy span weight and waits for a stable reading.
// R12: operator holds external inputs longer than 10 ms.
// R13: keys debounced, one action per press edge; function key hold timed.
module calibration_menu_sequencer import cal_menu_pkg::*; #(
  parameter int NDIG = 5,
  parameter int RD_W = 24,
  parameter int HOLD_CYC = `FNC_HOLD_MS * (`CLK_HZ / 1000),
  parameter int SHOW_CYC = `SPAN_SHOW_MS * (`CLK_HZ / 1000),
  parameter int DEB_CYC = `DEBOUNCE_US * (`CLK_HZ / 1000000)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fnc_key,
  input wire logic right_key,
  input wire logic up_key,
  input wire logic down_key,
  input wire logic enter_key,
  input wire logic cancel_key,
  input wire logic [RD_W-1:0] raw_reading,
  output logic [RD_W-1:0] min_division,
  output logic [RD_W-1:0] capacity,
  output logic [RD_W-1:0] zero_point,
  output logic [RD_W-1:0] rated_output,
  output logic [RD_W-1:0] span_weight,
  output logic [RD_W-1:0] span_count,
  output logic zero_strobe,
  output logic cal_update,
  output logic [11:0] disp_state,
  output logic [4*NDIG-1:0] disp_entry,
  output logic [3:0] disp_digit
);

  localparam int DW = $clog2(NDIG);

  state_t state, next_state;
  mode_t cur_mode;
  logic [31:0] ctrl;
  logic [31:0] hold_cnt;
  logic [31:0] show_cnt;
  logic [4*NDIG-1:0] entry;
  logic [DW-1:0] digit_sel;
  logic [3:0] cur_dig;
  logic [RD_W-1:0] entry_bin;
  logic res_ok, res_error, hold_fire, in_entry, in_step;
  logic [`KEY_NUM-1:0] key_raw, key_lvl, key_press;
  logic k_cancel, k_enter, k_right, k_up, k_down;
  logic [31:0] rd_mux;
  logic rd_hit;
  state_t top_state;

  // ----------------------------------------
  // key debouncing
  // ----------------------------------------
  assign key_raw = {fnc_key, down_key, up_key, right_key, enter_key, cancel_key};

  for (genvar i = 0; i < `KEY_NUM; i++) begin : g_key
    key_debounce #(.CNT(DEB_CYC)) u_deb (
      .pclk(pclk),
      .presetn(presetn),
      .raw(key_raw[i]),
      .level(key_lvl[i]),
      .press(key_press[i])
    );
  end

  // one key acts per cycle, cancel first
  always_comb begin
    k_cancel = key_press[`KEY_CANCEL];
    k_enter = key_press[`KEY_ENTER] & ~k_cancel;
    k_right = key_press[`KEY_RIGHT] & ~k_cancel & ~k_enter;
    k_up = key_press[`KEY_UP] & ~k_cancel & ~k_enter & ~k_right;
    k_down = key_press[`KEY_DOWN] & ~k_cancel & ~k_enter & ~k_right & ~k_up;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [RD_W-1:0] bcd2bin(input logic [4*NDIG-1:0] b);
    logic [RD_W-1:0] acc;
    acc = '0;
    for (int i = NDIG - 1; i >= 0; i--) begin
      acc = RD_W'(acc * RD_W'(10)) + RD_W'(b[i*4 +: 4]);
    end
    return acc;
  endfunction : bcd2bin

  assign entry_bin = bcd2bin(entry);
  assign cur_dig = entry[digit_sel*4 +: 4];
  assign res_ok = 32'(entry_bin) < 32'(32'(min_division) * 32'(`RES_LIMIT)); // [R10]
  assign in_entry = (state == ST_DIV) || (state == ST_CAP) || (state == ST_VOLT) || (state == ST_SPAN);
  assign in_step = in_entry || (state == ST_ZERO) || (state == ST_SHOW) || (state == ST_DONE);
  assign hold_fire = (state == ST_MEAS) && key_lvl[`KEY_FNC] && ctrl[`CTRL_MENU_EN] &&
    (hold_cnt == 32'(HOLD_CYC - 1)); // [R1]

  always_comb begin
    case (cur_mode)
      MODE_LOAD: top_state = ST_SEL_LOAD;
      MODE_FULL: top_state = ST_SEL_FULL;
      default: top_state = ST_SEL_DSP;
    endcase
  end

  // ----------------------------------------
  // function key hold timer
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt <= 32'h0;
    end else if (state == ST_MEAS && key_lvl[`KEY_FNC] && ctrl[`CTRL_MENU_EN]) begin
      if (!hold_fire) begin
        hold_cnt <= hold_cnt + 32'h1; // [R1]
      end
    end else begin
      hold_cnt <= 32'h0;
    end
  end

  // ----------------------------------------
  // menu state machine
  // ----------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_MEAS: if (hold_fire) next_state = ST_FSEL; // [R1]
      ST_FSEL: begin
        if (k_cancel) next_state = ST_MEAS;
        else if (k_right) next_state = ST_SEL_DSP; // [R2]
      end
      ST_SEL_DSP: begin
        if (k_cancel) next_state = ST_MEAS; // [R8]
        else if (k_enter) next_state = ST_DIV; // [R3]
        else if (k_right) next_state = ST_SEL_LOAD; // [R2] [R8]
      end
      ST_SEL_LOAD: begin
        if (k_cancel) next_state = ST_MEAS; // [R8]
        else if (k_enter) next_state = ST_ZERO; // [R7]
        else if (k_right) next_state = ST_SEL_FULL; // [R2] [R8]
      end
      ST_SEL_FULL: begin
        if (k_cancel) next_state = ST_MEAS;
        else if (k_enter) next_state = ST_DIV; // [R9]
        else if (k_right) next_state = ST_SEL_DSP;
      end
      ST_DIV: begin
        if (k_cancel) next_state = top_state; // [R4]
        else if (k_enter) next_state = ST_CAP; // [R3] [R9]
      end
      ST_CAP: begin
        if (k_cancel) next_state = top_state; // [R4]
        else if (k_enter && res_ok) next_state = ST_ZERO; // [R10]
      end
      ST_ZERO: begin
        if (k_cancel) next_state = top_state; // [R4]
        else if (k_enter) next_state = (cur_mode == MODE_DSP) ? ST_VOLT : ST_SPAN; // [R6]
      end
      ST_VOLT: begin
        if (k_cancel) next_state = top_state; // [R4]
        else if (k_enter) next_state = ST_DONE; // [R3]
      end
      ST_SPAN: begin
        if (k_cancel) next_state = top_state; // [R4]
        else if (k_enter) next_state = ST_SHOW; // [R7] [R9]
      end
      ST_SHOW: begin
        if (k_cancel) next_state = top_state; // [R4]
        else if (show_cnt == 32'(SHOW_CYC - 1)) next_state = ST_DONE; // [R7]
      end
      ST_DONE: if (k_enter || k_cancel) next_state = top_state; // [R8] [R9]
      default: next_state = ST_MEAS;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_MEAS;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_mode <= MODE_DSP;
    end else if (next_state == ST_SEL_LOAD) begin
      cur_mode <= MODE_LOAD;
    end else if (next_state == ST_SEL_FULL) begin
      cur_mode <= MODE_FULL;
    end else if (next_state == ST_SEL_DSP) begin
      cur_mode <= MODE_DSP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      show_cnt <= 32'h0;
    end else if (state == ST_SHOW) begin
      show_cnt <= show_cnt + 32'h1; // [R7]
    end else begin
      show_cnt <= 32'h0;
    end
  end

  // ----------------------------------------
  // digit entry
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry <= '0;
      digit_sel <= '0;
    end else if (next_state != state) begin
      entry <= '0; // [R4]
      digit_sel <= '0;
    end else if (in_entry) begin
      if (k_right) begin
        digit_sel <= (digit_sel == DW'(NDIG - 1)) ? '0 : digit_sel + DW'(1); // [R5]
      end else if (k_up) begin
        entry[digit_sel*4 +: 4] <= (cur_dig == 4'h9) ? 4'h0 : cur_dig + 4'h1; // [R5]
      end else if (k_down) begin
        entry[digit_sel*4 +: 4] <= (cur_dig == 4'h0) ? 4'h9 : cur_dig - 4'h1; // [R5]
      end
    end
  end

  // ----------------------------------------
  // stored settings to measurement core
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_division <= '0;
      capacity <= '0;
      zero_point <= '0;
      rated_output <= '0;
      span_weight <= '0;
      span_count <= '0;
      zero_strobe <= 1'b0;
      cal_update <= 1'b0;
    end else begin
      zero_strobe <= 1'b0;
      cal_update <= (next_state == ST_DONE) && (state != ST_DONE);
      if (k_enter) begin
        case (state)
          ST_DIV: min_division <= entry_bin; // [R5]
          ST_CAP: if (res_ok) capacity <= entry_bin; // [R10]
          ST_ZERO: begin
            zero_point <= raw_reading; // [R6]
            zero_strobe <= 1'b1;
          end
          ST_VOLT: rated_output <= entry_bin; // [R3]
          ST_SPAN: begin
            span_weight <= entry_bin; // [R7]
            span_count <= raw_reading - zero_point;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_error <= 1'b0;
    end else if (state == ST_CAP && k_enter && !res_ok) begin
      res_error <= 1'b1; // [R10]
    end else if (state != ST_CAP) begin
      res_error <= 1'b0;
    end
  end

  // ----------------------------------------
  // display outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_state <= ST_MEAS;
      disp_entry <= '0;
      disp_digit <= 4'h0;
    end else begin
      disp_state <= state;
      disp_entry <= (state == ST_SHOW) ? (4*NDIG)'(span_count) : entry;
      disp_digit <= 4'(digit_sel);
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always_comb begin
    rd_hit = 1'b1;
    case (paddr)
      `REG_CTRL: rd_mux = ctrl;
      `REG_STATUS: rd_mux = 32'({res_error, cur_mode, 4'(digit_sel), state});
      `REG_MIN_DIV: rd_mux = 32'(min_division);
      `REG_CAPACITY: rd_mux = 32'(capacity);
      `REG_ZERO: rd_mux = 32'(zero_point);
      `REG_RATED: rd_mux = 32'(rated_output);
      `REG_SPAN_WT: rd_mux = 32'(span_weight);
      `REG_SPAN_CNT: rd_mux = 32'(span_count);
      `REG_ENTRY: rd_mux = 32'(entry_bin);
      default: begin
        rd_mux = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  assign pready = psel & penable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_mux;
      pslverr <= !rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
    end else if (pready && pwrite && paddr == `REG_CTRL) begin
      ctrl <= pwdata;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_hold_entry: assert property (state == ST_MEAS && next_state == ST_FSEL |->
    hold_cnt == 32'(HOLD_CYC - 1) && key_lvl[`KEY_FNC] && $past(key_lvl[`KEY_FNC]) && ctrl[`CTRL_MENU_EN])
    else $error("menu entered before hold time"); // [R1]
  a_mode_order: assert property (state == ST_SEL_DSP && k_right |=> state == ST_SEL_LOAD ##0
    cur_mode == MODE_LOAD) else $error("right key mode order broken"); // [R2]
  a_dsp_steps: assert property (state == ST_ZERO && cur_mode == MODE_DSP && k_enter |=> state == ST_VOLT)
    else $error("digital span skips voltage step"); // [R3]
  a_cancel_top: assert property (in_step && k_cancel |=> state == $past(top_state) && entry == '0)
    else $error("cancel did not return to top"); // [R4]
  a_digit_up: assert property (in_entry && k_up && cur_dig == 4'h4 && next_state == state |=>
    entry[$past(digit_sel)*4 +: 4] == 4'h5) else $error("up key did not raise digit"); // [R5]
  a_zero_capture: assert property (state == ST_ZERO && k_enter |=> zero_point == $past(raw_reading)
    && zero_strobe) else $error("zero point not captured"); // [R6]
  a_span_show: assert property (state == ST_SHOW && !k_cancel |-> show_cnt < 32'(SHOW_CYC))
    else $error("span shown too long"); // [R7]
  a_done_return: assert property (state == ST_DONE && k_enter |=> state == ST_SEL_DSP ||
    state == ST_SEL_LOAD || state == ST_SEL_FULL) else $error("completion enter not to top"); // [R8]
  a_full_order: assert property (state == ST_SPAN && k_enter |=> state == ST_SHOW ##1 cal_update == 1'b0)
    else $error("span step did not show value"); // [R9]
  a_res_limit: assert property (state == ST_CAP && k_enter && !res_ok |=> state == ST_CAP && res_error
    && capacity == $past(capacity)) else $error("resolution limit not enforced"); // [R10]

  c_dsp_done: cover property (state == ST_VOLT && k_enter);
  c_load_show: cover property (state == ST_SHOW ##1 state == ST_DONE);
  c_cancel: cover property (state == ST_CAP && k_cancel);
  c_res_reject: cover property (state == ST_CAP && k_enter && !res_ok);

endmodule : calibration_menu_sequencer

// ### design/cal_menu_defines.svh
`ifndef CAL_MENU_DEFINES_SVH
`define CAL_MENU_DEFINES_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define CLK_HZ 100000000
`define FNC_HOLD_MS 3000
`define SPAN_SHOW_MS 2000
`define DEBOUNCE_US 5000
`define RES_LIMIT 10000

// ----------------------------------------
// key vector positions
// ----------------------------------------
`define KEY_CANCEL 0
`define KEY_ENTER 1
`define KEY_RIGHT 2
`define KEY_UP 3
`define KEY_DOWN 4
`define KEY_FNC 5
`define KEY_NUM 6

// ----------------------------------------
// apb register map
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MIN_DIV 8'h08
`define REG_CAPACITY 8'h0c
`define REG_ZERO 8'h10
`define REG_RATED 8'h14
`define REG_SPAN_WT 8'h18
`define REG_SPAN_CNT 8'h1c
`define REG_ENTRY 8'h20
`define CTRL_RESET 32'h0000_0001
`define CTRL_MENU_EN 0

`endif

// ### design/cal_menu_pkg.sv
package cal_menu_pkg;

  // ----------------------------------------
  // menu states, one-hot
  // ----------------------------------------
  typedef enum logic [11:0] {
    ST_MEAS = 12'h001,
    ST_FSEL = 12'h002,
    ST_SEL_DSP = 12'h004,
    ST_SEL_LOAD = 12'h008,
    ST_SEL_FULL = 12'h010,
    ST_DIV = 12'h020,
    ST_CAP = 12'h040,
    ST_ZERO = 12'h080,
    ST_VOLT = 12'h100,
    ST_SPAN = 12'h200,
    ST_SHOW = 12'h400,
    ST_DONE = 12'h800
  } state_t;

  // ----------------------------------------
  // calibration modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_DSP = 2'h0,
    MODE_LOAD = 2'h1,
    MODE_FULL = 2'h2
  } mode_t;

endpackage : cal_menu_pkg

// ### design/key_debounce.sv
`timescale 1ns/100ps

module key_debounce #(
  parameter int CNT = 500000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw,
  output logic level,
  output logic press
);

  logic [31:0] cnt;

  // ----------------------------------------
  // stability counter, one pulse per press
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 32'h0;
      level <= 1'b0;
      press <= 1'b0;
    end else begin
      press <= 1'b0;
      if (raw == level) begin
        cnt <= 32'h0;
      end else if (cnt == 32'(CNT - 1)) begin
        cnt <= 32'h0;
        level <= raw;
        press <= raw; // [R13]
      end else begin
        cnt <= cnt + 32'h1;
      end
    end
  end

  a_press_single: assert property (@(posedge pclk) disable iff (!presetn)
    press |=> !press && level) else $error("press pulse longer than one cycle"); // [R13]

endmodule : key_debounce

// ### test/key_operator.sv
`timescale 1ns/100ps

// ----------------------------------------
// front-panel operator, one key at a time
// ----------------------------------------
module key_operator (
  input wire logic pclk,
  output logic [5:0] key_lvl
);
  // all keys released, called once before reset ends
  task idle;
    key_lvl <= 6'h00;
  endtask : idle

  task press(input int idx, input int hold);
    key_lvl[idx] <= 1'b1;
    repeat (hold) @(posedge pclk);
    key_lvl[idx] <= 1'b0;
    repeat (hold) @(posedge pclk);
  endtask : press
endmodule : key_operator

// ### test/testbench.sv
`timescale 1ns/100ps
`include "cal_menu_defines.svh"

module testbench import cal_menu_pkg::*; ;
  localparam int DEB = 3;
  localparam int HOLD = 20;
  localparam int SHOW = 10;
  localparam int PRESS = DEB + 2;
  localparam int LIMIT = 20000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, zero_strobe, cal_update, zs_d;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] raw_reading, zr, dl, zero_point;
  logic [11:0] disp_state, last_st;
  logic [5:0] keys;
  logic [19:0] de;
  logic [3:0] dd;
  logic [31:0] rd_q[$];
  logic er_q[$];
  logic [11:0] st_q[$];
  logic [23:0] z_q[$];
  int err_count, checked, cyc, show_cyc, upd_n, seed;

  // ----------------------------------------
  // clock, design and operator
  // ----------------------------------------
  always #5 pclk = ~pclk;

  calibration_menu_sequencer #(.NDIG(5), .RD_W(24), .HOLD_CYC(HOLD), .SHOW_CYC(SHOW), .DEB_CYC(DEB)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fnc_key(keys[`KEY_FNC]), .right_key(keys[`KEY_RIGHT]), .up_key(keys[`KEY_UP]),
    .down_key(keys[`KEY_DOWN]), .enter_key(keys[`KEY_ENTER]), .cancel_key(keys[`KEY_CANCEL]),
    .raw_reading(raw_reading), .min_division(), .capacity(), .zero_point(zero_point), .rated_output(),
    .span_weight(), .span_count(), .zero_strobe(zero_strobe), .cal_update(cal_update),
    .disp_state(disp_state), .disp_entry(de), .disp_digit(dd)
  );

  key_operator u_op (.pclk(pclk), .key_lvl(keys));

  // ----------------------------------------
  // comparison and closing
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  task apb(input logic wr, input logic [7:0] addr, input logic [31:0] wd, input logic [31:0] exp, input logic err);
    if (!wr) begin
      rd_q.push_back(exp);
      er_q.push_back(err);
    end
    psel <= 1'b1;
    paddr <= addr;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task step(input int k, input logic [11:0] exp);
    if (exp != 12'h000) st_q.push_back(exp);
    u_op.press(k, PRESS);
  endtask : step

  task type_val(input int v);
    int d;
    logic [19:0] bcd;
    bcd = 20'h0;
    for (int i = 0; i < 5; i++) begin
      d = v % 10;
      v = v / 10;
      bcd[i*4 +: 4] = 4'(d);
      if (d == 9) step(`KEY_DOWN, 12'h000);
      else repeat (d) step(`KEY_UP, 12'h000);
      step(`KEY_RIGHT, 12'h000);
      check({28'h0, dd}, 32'((i + 1) % 5));
    end
    check({12'h0, de}, {12'h0, bcd});
  endtask : type_val

  task zero_then(input logic [11:0] exp);
    zr = 24'($urandom_range(0, 32'h7fffff));
    raw_reading <= zr;
    z_q.push_back(zr);
    step(`KEY_ENTER, exp);
  endtask : zero_then

  task span_then(input int w);
    type_val(w);
    dl = 24'($urandom_range(1, 32'h7fffff));
    raw_reading <= zr + dl;
    st_q.push_back(ST_SHOW);
    step(`KEY_ENTER, ST_DONE);
    repeat (SHOW + 5) @(posedge pclk);
  endtask : span_then

  task to_fsel;
    st_q.push_back(ST_FSEL);
    u_op.press(`KEY_FNC, HOLD + 10);
  endtask : to_fsel

  // ----------------------------------------
  // monitors
  // ----------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    zs_d <= zero_strobe;
    last_st <= disp_state;
    if (cal_update === 1'b1) upd_n++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      check(prdata, rd_q.pop_front());
      check({31'h0, pslverr}, {31'h0, er_q.pop_front()});
    end
    if (zs_d === 1'b1) check({8'h0, zero_point}, {8'h0, z_q.pop_front()});
    if (presetn && disp_state !== last_st) begin
      if (st_q.size() == 0) check({20'h0, disp_state}, 32'hffff_ffff);
      else check({20'h0, disp_state}, {20'h0, st_q.pop_front()});
      if (disp_state === ST_SHOW) begin
        show_cyc <= cyc;
        check({12'h0, de}, {12'h0, dl[19:0]});
      end
      if (disp_state === ST_DONE && last_st === ST_SHOW)
        check(32'(cyc - show_cyc >= SHOW - 1 && cyc - show_cyc <= SHOW + 1), 32'h1);
    end
    if (cyc == LIMIT) begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    u_op.idle();
    paddr = 8'h00;
    pwdata = 32'h0;
    raw_reading = 24'h0;
    seed = $urandom(32'hdcac);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `REG_CTRL, 32'h0, `CTRL_RESET, 1'b0);
    apb(1'b0, `REG_STATUS, 32'h0, 32'h1, 1'b0);
    apb(1'b0, 8'h24, 32'h0, 32'h0, 1'b1);
    apb(1'b1, `REG_CAPACITY, 32'h1234, 32'h0, 1'b0);
    apb(1'b0, `REG_CAPACITY, 32'h0, 32'h0, 1'b0);
    u_op.press(`KEY_FNC, HOLD / 2);
    apb(1'b1, `REG_CTRL, 32'h0, 32'h0, 1'b0);
    u_op.press(`KEY_FNC, HOLD + 10);
    apb(1'b1, `REG_CTRL, `CTRL_RESET, 32'h0, 1'b0);
    to_fsel();
    step(`KEY_RIGHT, ST_SEL_DSP);
    step(`KEY_RIGHT, ST_SEL_LOAD);
    step(`KEY_RIGHT, ST_SEL_FULL);
    step(`KEY_RIGHT, ST_SEL_DSP);
    step(`KEY_ENTER, ST_DIV);
    type_val(1);
    step(`KEY_ENTER, ST_CAP);
    type_val(10000);
    apb(1'b0, `REG_ENTRY, 32'h0, 32'd10000, 1'b0);
    step(`KEY_ENTER, 12'h000);
    apb(1'b0, `REG_STATUS, 32'h0, 32'h0004_0040, 1'b0);
    step(`KEY_CANCEL, ST_SEL_DSP);
    step(`KEY_ENTER, ST_DIV);
    type_val(1);
    step(`KEY_ENTER, ST_CAP);
    type_val(9999);
    step(`KEY_ENTER, ST_ZERO);
    zero_then(ST_VOLT);
    type_val(123);
    step(`KEY_ENTER, ST_DONE);
    step(`KEY_ENTER, ST_SEL_DSP);
    apb(1'b0, `REG_MIN_DIV, 32'h0, 32'd1, 1'b0);
    apb(1'b0, `REG_CAPACITY, 32'h0, 32'd9999, 1'b0);
    apb(1'b0, `REG_ZERO, 32'h0, {8'h0, zr}, 1'b0);
    apb(1'b0, `REG_RATED, 32'h0, 32'd123, 1'b0);
    step(`KEY_RIGHT, ST_SEL_LOAD);
    step(`KEY_ENTER, ST_ZERO);
    zero_then(ST_SPAN);
    span_then(50);
    step(`KEY_ENTER, ST_SEL_LOAD);
    apb(1'b0, `REG_SPAN_WT, 32'h0, 32'd50, 1'b0);
    apb(1'b0, `REG_SPAN_CNT, 32'h0, {8'h0, dl}, 1'b0);
    step(`KEY_CANCEL, ST_MEAS);
    to_fsel();
    step(`KEY_RIGHT, ST_SEL_DSP);
    step(`KEY_RIGHT, ST_SEL_LOAD);
    step(`KEY_RIGHT, ST_SEL_FULL);
    step(`KEY_ENTER, ST_DIV);
    type_val(2);
    step(`KEY_ENTER, ST_CAP);
    type_val(100);
    step(`KEY_ENTER, ST_ZERO);
    zero_then(ST_SPAN);
    span_then(7);
    step(`KEY_ENTER, ST_SEL_FULL);
    apb(1'b0, `REG_MIN_DIV, 32'h0, 32'd2, 1'b0);
    apb(1'b0, `REG_CAPACITY, 32'h0, 32'd100, 1'b0);
    apb(1'b0, `REG_SPAN_CNT, 32'h0, {8'h0, dl}, 1'b0);
    check(32'(upd_n), 32'd3);
    check(32'(st_q.size()), 32'h0);
    final_report();
  end
endmodule : testbench
